// File: bench/irq_pin_host.sv
`timescale 1ns/1ns
// ************************************************************
// Host side of the interrupt pin, line pulled up
// ************************************************************
module irq_pin_host (
   // Pin from the device
   input  wire irq_status_enable_pkg::irq_pin_t irqPin,
   // Level the host sees
   output logic                                 pinLevel
);
   import irq_status_enable_pkg::*;
   // Released open-drain line floats to the pull-up, never to the last value
   assign pinLevel = irqPin.pinOe ? irqPin.pinOut : 1'b1;
endmodule

// File: bench/irq_status_enable_unit_tb.sv
`timescale 1ns/1ns
`include "irq_status_enable_defines.svh"
module irq_status_enable_unit_tb;
   import irq_status_enable_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        slvErr;
   events_t     events = '0;
   logic [15:0] knownCmdMask = 16'h0003;
   logic [3:0]  activeCmd;
   irq_pin_t    irqPin;
   logic        pinLevel;
   logic [31:0] q;
   events_t     ev;
   int          n_mismatch = 0;
   int          checked = 0;

   irq_status_enable_unit i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .events(events), .knownCmdMask(knownCmdMask),
      .activeCmd(activeCmd), .irqPin(irqPin));
   irq_pin_host i_host (.irqPin(irqPin), .pinLevel(pinLevel));

   always #2 clk = ~clk;

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic give_verdict();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask

   // Zero-wait slave, but the wait stays bounded in case pready never comes
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         give_verdict();
      end
      q = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, q);
   endtask

   task automatic pulse(input events_t e);
      @(posedge clk);
      events <= e;
      @(posedge clk);
      events <= '0;
   endtask

   task automatic pinchk(input logic [1:0] exp, input logic lvl);
      @(posedge clk);
      #1;
      chk("pin", {30'h0, exp}, {30'h0, irqPin.pinOe, irqPin.pinOut});
      chk("level", {31'h0, lvl}, {31'h0, pinLevel});
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      rdchk("reqMain", `REQ_MAIN_ADDR, 32'h00);
      rdchk("reqTmr", `REQ_TMR_ADDR, 32'h00);
      rdchk("enMain", `EN_MAIN_ADDR, 32'h00);
      pinchk(2'b10, 1'b0);
      $display("t_reset done");
   endtask

   task automatic t_setclr();
      apb(1'b1, `REQ_MAIN_ADDR, 32'hFF);
      rdchk("reqMain", `REQ_MAIN_ADDR, 32'h7F);
      apb(1'b1, `REQ_MAIN_ADDR, 32'h05);
      rdchk("reqMain", `REQ_MAIN_ADDR, 32'h7A);
      apb(1'b1, `REQ_TMR_ADDR, 32'hFF);
      rdchk("reqTmr", `REQ_TMR_ADDR, 32'h3F);
      apb(1'b1, `REQ_TMR_ADDR, 32'h14);
      rdchk("reqTmr", `REQ_TMR_ADDR, 32'h2B);
      rdchk("unmapped", 12'h030, 32'h0);
      chk("slverr", 32'h1, {31'h0, slvErr});
      apb(1'b1, `REQ_MAIN_ADDR, 32'h7F);
      apb(1'b1, `REQ_TMR_ADDR, 32'h3F);
      $display("t_setclr done");
   endtask

   task automatic t_events();
      ev = '0;
      ev.fifoHighAlertStatus = 1'b1;
      ev.fifoLowAlertStatus = 1'b1;
      ev.transmitLastBit = 1'b1;
      ev.receiveEnd = 1'b1;
      ev.protocolError = 1'b1;
      ev.subcarrierSeen = 1'b1;
      pulse(ev);
      rdchk("reqMain", `REQ_MAIN_ADDR, 32'h6F);
      apb(1'b1, `REQ_MAIN_ADDR, 32'h7F);
      ev = '0;
      ev.integrityError = 1'b1;
      ev.frameStartSeen = 1'b1;
      ev.cardDetected = 1'b1;
      ev.timerUnderflow = 5'h15;
      pulse(ev);
      rdchk("reqMain", `REQ_MAIN_ADDR, 32'h03);
      rdchk("reqTmr", `REQ_TMR_ADDR, 32'h35);
      apb(1'b1, `REQ_MAIN_ADDR, 32'h7F);
      apb(1'b1, `REQ_TMR_ADDR, 32'h3F);
      $display("t_events done");
   endtask

   task automatic t_pin();
      apb(1'b1, `REQ_MAIN_ADDR, 32'h88);
      apb(1'b1, `EN_MAIN_ADDR, 32'h08);
      apb(1'b1, `EN_TMR_ADDR, 32'hC0);
      rdchk("global", `REQ_TMR_ADDR, 32'h40);
      pinchk(2'b11, 1'b1);
      apb(1'b1, `EN_MAIN_ADDR, 32'h88);
      pinchk(2'b10, 1'b0);
      apb(1'b1, `EN_TMR_ADDR, 32'h40);
      pinchk(2'b10, 1'b0);
      apb(1'b1, `EN_MAIN_ADDR, 32'h08);
      pinchk(2'b00, 1'b1);
      apb(1'b1, `EN_TMR_ADDR, 32'h00);
      pinchk(2'b10, 1'b0);
      rdchk("enMain", `EN_MAIN_ADDR, 32'h08);
      rdchk("enTmr", `EN_TMR_ADDR, 32'h00);
      apb(1'b1, `REQ_MAIN_ADDR, 32'h7F);
      rdchk("global", `REQ_TMR_ADDR, 32'h00);
      $display("t_pin done");
   endtask

   task automatic t_cmd();
      apb(1'b1, `CMD_ADDR, 32'h05);
      rdchk("reqMain", `REQ_MAIN_ADDR, 32'h10);
      chk("cmd", 32'h0, {28'h0, activeCmd});
      apb(1'b1, `REQ_MAIN_ADDR, 32'h7F);
      apb(1'b1, `CMD_ADDR, 32'h01);
      @(posedge clk);
      chk("cmd", 32'h1, {28'h0, activeCmd});
      rdchk("cmdReg", `CMD_ADDR, 32'h01);
      ev = '0;
      ev.commandFinished = 1'b1;
      pulse(ev);
      rdchk("reqMain", `REQ_MAIN_ADDR, 32'h10);
      apb(1'b1, `REQ_MAIN_ADDR, 32'h7F);
      apb(1'b1, `CMD_ADDR, 32'h01);
      apb(1'b1, `CMD_ADDR, 32'h00);
      rdchk("reqMain", `REQ_MAIN_ADDR, 32'h00);
      $display("t_cmd done");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_setclr();
      t_events();
      t_pin();
      t_cmd();
      give_verdict();
   end
endmodule

// File: verilog/irq_status_enable_defines.svh
`ifndef IRQ_STATUS_ENABLE_DEFINES_SVH
`define IRQ_STATUS_ENABLE_DEFINES_SVH

// ************************************************************
// Register byte addresses (offsets are multiples of four: index * 4)
// ************************************************************
`define REQ_MAIN_IDX      8'h06
`define REQ_TMR_IDX       8'h07
`define EN_MAIN_IDX       8'h08
`define EN_TMR_IDX        8'h09
`define CMD_IDX           8'h0A
`define REQ_MAIN_ADDR     12'h018
`define REQ_TMR_ADDR      12'h01C
`define EN_MAIN_ADDR      12'h020
`define EN_TMR_ADDR       12'h024
`define CMD_ADDR          12'h028

// ************************************************************
// Field positions and reset values
// ************************************************************
`define SET_SEL_BIT       7
`define GLOBAL_BIT        6
`define PIN_INV_BIT       7
`define PIN_EN_BIT        6
`define PUSH_PULL_BIT     7
`define REQ_MAIN_RST      7'h00
`define REQ_TMR_RST       6'h00
`define EN_RST            8'h00
`define CMD_IDLE          4'h0
`define CMD_RST           4'h0

`endif

// File: verilog/irq_status_enable_pkg.sv
package irq_status_enable_pkg;

   // Live event inputs from the rest of the frontend
   typedef struct packed {
      logic       fifoHighAlertStatus;
      logic       fifoLowAlertStatus;
      logic       commandFinished;
      logic       transmitLastBit;
      logic       receiveEnd;
      logic       fifoWriteError;
      logic       fifoOverflowError;
      logic       protocolError;
      logic       noDataError;
      logic       integrityError;
      logic       frameStartSeen;
      logic       subcarrierSeen;
      logic       cardDetected;
      logic [4:0] timerUnderflow;
   } events_t;

   // Open-drain/push-pull interrupt pin
   typedef struct packed {
      logic pinOut;
      logic pinOe;
   } irq_pin_t;

endpackage

// File: verilog/irq_status_enable_unit.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Written bit 7 selects set or clear
// - Only bits written one change
// - Main request register 06h, resets 00h
// - High alert request latches on rise
// - Low alert request latches on rise
// - Self-finished command sets idle request
// - Unknown command returns idle, sets request
// - Host idle command sets no request
// - Transmit request set after last bit
// - Receive request set at stream end
// - Rise of the ORed error flags sets error
// - Frame start or subcarrier sets request
// - Timer register 07h, bits 5..0 writable
// - Global request is enabled-request OR
// - Card detection sets bit 5
// - Timer underflows set bits 4..0
// - Main enable register 08h gates requests
// - Enable bit 7 inverts pin level
// - Timer enable register 09h bits 5..0
// - Pin active only with pin enable
// - Bit 7 selects push-pull or open-drain
`include "irq_status_enable_defines.svh"

module irq_status_enable_unit #(
   parameter int CMD_W = 4
) (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            reset,
   // APB slave
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [11:0]                     paddr,
   input  wire logic [31:0]                     pwdata,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   // Event sources
   input  wire irq_status_enable_pkg::events_t  events,
   input  wire logic [15:0]                     knownCmdMask,
   // Command field towards the sequencer
   output logic      [CMD_W-1:0]                activeCmd,
   // Interrupt pin
   output irq_status_enable_pkg::irq_pin_t      irqPin
);
   import irq_status_enable_pkg::*;

   // ************************************************************
   // Bus decode
   // ************************************************************
   logic [6:0]       reqMain_ff, nxt_reqMain;
   logic [5:0]       reqTmr_ff,  nxt_reqTmr;
   logic [7:0]       enMain_ff;
   logic [7:0]       enTmr_ff;
   logic [CMD_W-1:0] cmd_ff;
   logic             hiPrev_ff, loPrev_ff, errPrev_ff;
   logic             globalReq;
   logic [31:0]      rdMux;

   wire wrEn      = psel & penable & pwrite;
   wire hitReqM   = (paddr == `REQ_MAIN_ADDR);
   wire hitReqT   = (paddr == `REQ_TMR_ADDR);
   wire hitEnM    = (paddr == `EN_MAIN_ADDR);
   wire hitEnT    = (paddr == `EN_TMR_ADDR);
   wire hitCmd    = (paddr == `CMD_ADDR);
   wire hitAny    = hitReqM | hitReqT | hitEnM | hitEnT | hitCmd;
   wire setSel    = pwdata[`SET_SEL_BIT];
   wire wrReqM    = wrEn & hitReqM;
   wire wrReqT    = wrEn & hitReqT;
   wire wrCmd     = wrEn & hitCmd;
   wire wrEnM     = wrEn & hitEnM;
   wire wrEnT     = wrEn & hitEnT;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hitAny;

   // ************************************************************
   // Event detection
   // ************************************************************
   wire errNow   = events.fifoWriteError | events.fifoOverflowError | events.protocolError
                 | events.noDataError | events.integrityError;
   wire hiRise   = events.fifoHighAlertStatus & ~hiPrev_ff;
   wire loRise   = events.fifoLowAlertStatus & ~loPrev_ff;
   wire errRise  = errNow & ~errPrev_ff;
   wire [CMD_W-1:0] wrCode = pwdata[CMD_W-1:0];
   // Unknown codes bounce straight back to idle
   wire unknownCmd = wrCmd & ~knownCmdMask[wrCode];
   // Host writing idle is a stop, not a completion
   wire selfDone = events.commandFinished & (cmd_ff != `CMD_IDLE) & ~wrCmd;
   wire idleSet  = selfDone | unknownCmd;

   wire [6:0] evMain = {hiRise, loRise, idleSet, events.transmitLastBit,
                        events.receiveEnd, errRise,
                        events.frameStartSeen | events.subcarrierSeen};
   wire [5:0] evTmr  = {events.cardDetected, events.timerUnderflow};

   // Write mask: set or clear only targeted bits; hardware events win
   wire [6:0] wMaskM = wrReqM ? pwdata[6:0] : 7'h00;
   wire [5:0] wMaskT = wrReqT ? pwdata[5:0] : 6'h00;

   always_comb begin
      nxt_reqMain = setSel ? (reqMain_ff | wMaskM) : (reqMain_ff & ~wMaskM);
      nxt_reqMain = nxt_reqMain | evMain;
      nxt_reqTmr  = setSel ? (reqTmr_ff | wMaskT) : (reqTmr_ff & ~wMaskT);
      nxt_reqTmr  = nxt_reqTmr | evTmr;
   end

   // ************************************************************
   // Request registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         reqMain_ff <= `REQ_MAIN_RST;
      end else begin
         reqMain_ff <= nxt_reqMain;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reqTmr_ff <= `REQ_TMR_RST;
      end else begin
         reqTmr_ff <= nxt_reqTmr;
      end
   end

   // ************************************************************
   // Event history
   // ************************************************************
   // History resets low: a status already high at release counts as a rise
   always_ff @(posedge clk) begin
      if (reset) begin
         hiPrev_ff  <= 1'b0;
         loPrev_ff  <= 1'b0;
         errPrev_ff <= 1'b0;
      end else begin
         hiPrev_ff  <= events.fifoHighAlertStatus;
         loPrev_ff  <= events.fifoLowAlertStatus;
         errPrev_ff <= errNow;
      end
   end

   // ************************************************************
   // Enable registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         enMain_ff <= `EN_RST;
      end else if (wrEnM) begin
         enMain_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         enTmr_ff <= `EN_RST;
      end else if (wrEnT) begin
         enTmr_ff <= pwdata[7:0];
      end
   end

   // ************************************************************
   // Command field
   // ************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_ff <= CMD_W'(`CMD_RST);
      end else if (wrCmd) begin
         cmd_ff <= unknownCmd ? CMD_W'(`CMD_IDLE) : wrCode;
      end else if (events.commandFinished) begin
         cmd_ff <= CMD_W'(`CMD_IDLE);
      end
   end

   assign activeCmd = cmd_ff;

   // ************************************************************
   // Global request and pin
   // ************************************************************
   // Live recompute; no storage, so writes cannot reach it
   assign globalReq = |(reqMain_ff & enMain_ff[6:0]) | |(reqTmr_ff & enTmr_ff[5:0]);

   wire pinActive = globalReq & enTmr_ff[`PIN_EN_BIT];
   wire pinLevel  = pinActive ^ enMain_ff[`PIN_INV_BIT];

   always_comb begin
      // Open-drain can only pull low: drive when level is low
      if (enTmr_ff[`PUSH_PULL_BIT]) begin
         irqPin.pinOut = pinLevel;
         irqPin.pinOe  = 1'b1;
      end else begin
         irqPin.pinOut = 1'b0;
         irqPin.pinOe  = ~pinLevel;
      end
   end

   // ************************************************************
   // Read mux
   // ************************************************************
   // Request bit 7 is write-only and always reads back zero
   wire [31:0] rdReqM = {25'h0, reqMain_ff};
   wire [31:0] rdReqT = {24'h0, 1'b0, globalReq, reqTmr_ff};
   wire [31:0] rdEnM  = {24'h0, enMain_ff};
   wire [31:0] rdEnT  = {24'h0, enTmr_ff};
   wire [31:0] rdCmd  = {{(32-CMD_W){1'b0}}, cmd_ff};
   wire        rdTake = psel & ~penable & ~pwrite;

   assign rdMux = ({32{hitReqM}} & rdReqM) | ({32{hitReqT}} & rdReqT)
                | ({32{hitEnM}} & rdEnM) | ({32{hitEnT}} & rdEnT)
                | ({32{hitCmd}} & rdCmd);

   // Captured in the setup cycle so the access cycle sees a settled word
   always_ff @(posedge clk) begin
      if (reset) prdata <= 32'h0000_0000;
      else if (rdTake) prdata <= rdMux;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   set_write_a: assert property (@(posedge clk) disable iff (reset)
      wrReqM & setSel |=> (reqMain_ff & $past(pwdata[6:0])) == $past(pwdata[6:0]))
      else $error("set write did not set bits");
   clear_keep_a: assert property (@(posedge clk) disable iff (reset)
      wrReqM & ~setSel & (evMain == 7'h00)
      |=> reqMain_ff == ($past(reqMain_ff) & ~$past(pwdata[6:0])))
      else $error("clear write wrong");
   high_alert_a: assert property (@(posedge clk) disable iff (reset)
      hiRise |=> reqMain_ff[6]) else $error("high alert not latched");
   low_alert_a: assert property (@(posedge clk) disable iff (reset)
      loRise |=> reqMain_ff[5]) else $error("low alert not latched");
   unknown_cmd_a: assert property (@(posedge clk) disable iff (reset)
      unknownCmd |=> cmd_ff == `CMD_IDLE && reqMain_ff[4]) else $error("unknown cmd");
   host_idle_a: assert property (@(posedge clk) disable iff (reset)
      wrCmd & (wrCode == `CMD_IDLE) & knownCmdMask[0] & ~reqMain_ff[4] & ~wrReqM
      |=> ~reqMain_ff[4]) else $error("host idle set request");
   timer_set_a: assert property (@(posedge clk) disable iff (reset)
      events.timerUnderflow[0] |=> reqTmr_ff[0]) else $error("timer lost");
   pin_off_a: assert property (@(posedge clk) disable iff (reset)
      ~enTmr_ff[`PIN_EN_BIT] & enTmr_ff[`PUSH_PULL_BIT]
      |-> irqPin.pinOut == enMain_ff[`PIN_INV_BIT]) else $error("pin not idle");
   global_a: assert property (@(posedge clk) disable iff (reset)
      (reqTmr_ff[5] & enTmr_ff[5]) |-> globalReq) else $error("global missing");


   // ************************************************************
   // Checks on the main request register and command field
   // ************************************************************
   reset_main_a: assert property (@(posedge clk) disable iff (reset)
      $past(reset) |-> reqMain_ff == `REQ_MAIN_RST)
      else $error("main request not cleared by reset");
   keep_other_a: assert property (@(posedge clk) disable iff (reset)
      wrReqM & (evMain == 7'h00)
      |=> (reqMain_ff & ~$past(pwdata[6:0])) == ($past(reqMain_ff) & ~$past(pwdata[6:0])))
      else $error("untargeted request bit changed");
   clear_all_a: assert property (@(posedge clk) disable iff (reset)
      wrReqM & ~setSel & (pwdata[6:0] == 7'h7F) & (evMain == 7'h00)
      |=> reqMain_ff == 7'h00)
      else $error("clear of all bits failed");
   event_wins_a: assert property (@(posedge clk) disable iff (reset)
      wrReqM & ~setSel & events.transmitLastBit |=> reqMain_ff[3])
      else $error("clear beat a transmit event");
   high_hold_a: assert property (@(posedge clk) disable iff (reset)
      reqMain_ff[6] & ~wrReqM |=> reqMain_ff[6])
      else $error("high alert request lost");
   low_hold_a: assert property (@(posedge clk) disable iff (reset)
      reqMain_ff[5] & ~wrReqM |=> reqMain_ff[5])
      else $error("low alert request lost");
   idle_self_a: assert property (@(posedge clk) disable iff (reset)
      selfDone |=> reqMain_ff[4] && (cmd_ff == CMD_W'(`CMD_IDLE)))
      else $error("self-finished command not flagged");
   host_stop_a: assert property (@(posedge clk) disable iff (reset)
      wrCmd & (wrCode == CMD_W'(`CMD_IDLE)) |=> cmd_ff == CMD_W'(`CMD_IDLE))
      else $error("host stop not taken");
   cmd_write_a: assert property (@(posedge clk) disable iff (reset)
      wrCmd & knownCmdMask[wrCode] |=> cmd_ff == $past(wrCode))
      else $error("known command not stored");
   transmit_a: assert property (@(posedge clk) disable iff (reset)
      events.transmitLastBit |=> reqMain_ff[3])
      else $error("transmit request missing");
   receive_a: assert property (@(posedge clk) disable iff (reset)
      events.receiveEnd |=> reqMain_ff[2])
      else $error("receive request missing");
   error_a: assert property (@(posedge clk) disable iff (reset)
      errNow & ~errPrev_ff |=> reqMain_ff[1])
      else $error("error request missing");
   frame_start_a: assert property (@(posedge clk) disable iff (reset)
      events.frameStartSeen | events.subcarrierSeen |=> reqMain_ff[0])
      else $error("frame start request missing");

   // ************************************************************
   // Checks on the timer and detect request register
   // ************************************************************
   reset_tmr_a: assert property (@(posedge clk) disable iff (reset)
      $past(reset) |-> reqTmr_ff == `REQ_TMR_RST && enMain_ff == `EN_RST && enTmr_ff == `EN_RST)
      else $error("timer request or enables not reset");
   tmr_set_a: assert property (@(posedge clk) disable iff (reset)
      wrReqT & setSel |=> (reqTmr_ff & $past(pwdata[5:0])) == $past(pwdata[5:0]))
      else $error("timer set write failed");
   tmr_clear_a: assert property (@(posedge clk) disable iff (reset)
      wrReqT & ~setSel & (evTmr == 6'h00)
      |=> reqTmr_ff == ($past(reqTmr_ff) & ~$past(pwdata[5:0])))
      else $error("timer clear write failed");
   tmr_keep_a: assert property (@(posedge clk) disable iff (reset)
      wrReqT & (evTmr == 6'h00)
      |=> (reqTmr_ff & ~$past(pwdata[5:0])) == ($past(reqTmr_ff) & ~$past(pwdata[5:0])))
      else $error("untargeted timer bit changed");
   card_detect_a: assert property (@(posedge clk) disable iff (reset)
      events.cardDetected |=> reqTmr_ff[5])
      else $error("card detect request missing");
   timer_all_a: assert property (@(posedge clk) disable iff (reset)
      (events.timerUnderflow != 5'h00)
      |=> (reqTmr_ff[4:0] & $past(events.timerUnderflow)) == $past(events.timerUnderflow))
      else $error("timer underflow request missing");
   global_main_a: assert property (@(posedge clk) disable iff (reset)
      ((reqMain_ff & enMain_ff[6:0]) != 7'h00) |-> globalReq)
      else $error("global missing for main request");
   global_tmr_a: assert property (@(posedge clk) disable iff (reset)
      ((reqTmr_ff & enTmr_ff[5:0]) != 6'h00) |-> globalReq)
      else $error("global missing for timer request");
   global_off_a: assert property (@(posedge clk) disable iff (reset)
      ((reqMain_ff & enMain_ff[6:0]) == 7'h00) && ((reqTmr_ff & enTmr_ff[5:0]) == 6'h00)
      |-> ~globalReq)
      else $error("global without enabled request");
   read_zero_a: assert property (@(posedge clk) disable iff (reset)
      rdTake & (hitReqM | hitReqT) |=> ~prdata[7])
      else $error("request bit 7 read back");

   // ************************************************************
   // Checks on enables, pin and bus
   // ************************************************************
   enable_main_a: assert property (@(posedge clk) disable iff (reset)
      wrEnM |=> enMain_ff == $past(pwdata[7:0]))
      else $error("main enable not written");
   enable_tmr_a: assert property (@(posedge clk) disable iff (reset)
      wrEnT |=> enTmr_ff == $past(pwdata[7:0]))
      else $error("timer enable not written");
   pin_invert_a: assert property (@(posedge clk) disable iff (reset)
      enTmr_ff[`PUSH_PULL_BIT] & enTmr_ff[`PIN_EN_BIT]
      |-> irqPin.pinOut == (globalReq ^ enMain_ff[`PIN_INV_BIT]))
      else $error("pin level wrong");
   pin_disabled_a: assert property (@(posedge clk) disable iff (reset)
      ~enTmr_ff[`PIN_EN_BIT] & ~enTmr_ff[`PUSH_PULL_BIT] |-> irqPin.pinOe == ~enMain_ff[`PIN_INV_BIT])
      else $error("disabled pin not idle");
   open_drain_a: assert property (@(posedge clk) disable iff (reset)
      ~enTmr_ff[`PUSH_PULL_BIT] |-> ~irqPin.pinOut)
      else $error("open-drain pin driven high");
   push_pull_a: assert property (@(posedge clk) disable iff (reset)
      enTmr_ff[`PUSH_PULL_BIT] |-> irqPin.pinOe)
      else $error("push-pull pin released");
   bus_ready_a: assert property (@(posedge clk) disable iff (reset)
      psel & penable |-> pready)
      else $error("access without ready");
   bus_error_a: assert property (@(posedge clk) disable iff (reset)
      psel & penable & ~hitAny |-> pslverr)
      else $error("unmapped access without error");
   bus_ok_a: assert property (@(posedge clk) disable iff (reset)
      psel & penable & hitAny |-> ~pslverr)
      else $error("mapped access flagged");
   no_write_a: assert property (@(posedge clk) disable iff (reset)
      psel & penable & pwrite & ~hitAny & ~events.commandFinished
      |=> $stable(enMain_ff) && $stable(enTmr_ff) && $stable(cmd_ff))
      else $error("unmapped write changed a register");
   prdata_hold_a: assert property (@(posedge clk) disable iff (reset)
      ~rdTake |=> $stable(prdata))
      else $error("read data moved outside setup");

   // ************************************************************
   // Cover points
   // ************************************************************
   cmd_done_c: cover property (@(posedge clk) disable iff (reset) selfDone);
   pin_fire_c: cover property (@(posedge clk) disable iff (reset) pinActive);
   clear_c:    cover property (@(posedge clk) disable iff (reset) wrReqM & ~setSel);
   unknown_c:  cover property (@(posedge clk) disable iff (reset) unknownCmd);
   release_c:  cover property (@(posedge clk) disable iff (reset) ~irqPin.pinOe);
endmodule
